// [unbm_pkg.sv]
// Package: constants and carrier types for the nine-bit multiprocessor UART
package unbm_pkg;

  localparam int unsigned DATA_W        = 8;
  localparam int unsigned TICKS_PER_BIT = 16;
  localparam int unsigned HALF_BIT      = 8;
  localparam int unsigned TICK_CNT_W    = 4;
  localparam int unsigned BIT_CNT_W     = 4;
  localparam int unsigned NUM_TIMERS    = 4;
  localparam int unsigned TSEL_W        = 2;
  // Frame: start, eight data, ninth, stop
  localparam logic [3:0]  FRAME_BITS    = 4'hb;
  localparam logic [3:0]  NINTH_IDX     = 4'h9;
  localparam logic [3:0]  STOP_IDX      = 4'ha;
  localparam logic [1:0]  MODE_NINE_VAR = 2'h3;
  localparam logic [1:0]  MODE_EIGHT_VAR = 2'h1;
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;

  typedef enum logic [1:0] {
    UNBM_IDLE  = 2'b00,
    UNBM_START = 2'b01,
    UNBM_DATA  = 2'b11
  } unbm_rx_state_t;

  // Address configuration travels together
  typedef struct packed {
    logic [DATA_W-1:0] own_slave_address;
    logic [DATA_W-1:0] address_mask;
  } unbm_addr_cfg_t;

  // Status flags shown to the CPU
  typedef struct packed {
    logic tx_collision_flag;
    logic rx_overrun_flag;
    logic frame_error_flag;
    logic rx_complete_flag;
    logic tx_complete_flag;
    logic rx_ninth_bit;
  } unbm_status_t;

endpackage

// [unbm_baud_sel.sv]
// Baud tick selector: picks one timer overflow and divides by sixteen
`timescale 1ns/1ns
module unbm_baud_sel
  import unbm_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  // Timer overflows and selection
  input  wire logic [NUM_TIMERS-1:0] timer_ovf_i,
  input  wire logic [TSEL_W-1:0]     timer_sel_i,
  // Restart phase at frame start
  input  wire logic                  restart_i,
  // Outputs
  output logic                       tick_o,
  output logic                       bit_o
);

  logic [TICK_CNT_W-1:0] div_ff;
  logic                  tick_ff;
  logic                  bit_ff;

  // Selector by index keeps transmit and receive choices independent
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= timer_ovf_i[timer_sel_i];
    end
  end

  // Sixteen overflow ticks form one bit time
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_ff <= '0;
      bit_ff <= 1'b0;
    end else if (restart_i) begin
      div_ff <= '0;
      bit_ff <= 1'b0;
    end else begin
      bit_ff <= 1'b0;
      if (tick_ff) begin
        div_ff <= div_ff + 4'h1;
        bit_ff <= (div_ff == 4'(TICKS_PER_BIT - 1));
      end
    end
  end

  assign tick_o = tick_ff;
  assign bit_o  = bit_ff;

endmodule

// [unbm_uart.sv]
// Nine-bit variable-rate UART with multiprocessor address recognition
`timescale 1ns/1ns
// Overview of operation
// - Frames are start, eight data LSB first, ninth bit, stop: eleven bits.
// - Bit timing comes from one of four timer overflow ticks.
// - Masked address compares only bits whose mask bit is 1.
// - Broadcast address is address OR mask; its ones must all be received.
// - Multiprocessor mode accepts only ninth bit 1 with masked or broadcast match.
// - Rejected frames leave the data buffer and receive flag untouched.
// - Writing the buffer during transmission sets the collision flag.
// - A byte latched before the previous one was read sets overrun.
// - A low stop bit sets the frame error flag.
// - Transmitted ninth bit comes from the transmit ninth bit flag.
// - Accepted receive stores byte, ninth bit, and sets receive complete.
// - Transmit complete sets at the start of the stop bit.
// - Transmit and receive timers are selected by separate two-bit fields.
module unbm_uart
  import unbm_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  // Mode and configuration
  input  wire logic                  mode_select_high_i,
  input  wire logic                  mode_select_low_i,
  input  wire logic                  multiproc_enable_i,
  input  wire logic                  rx_enable_i,
  input  wire logic                  tx_ninth_bit_i,
  input  wire unbm_addr_cfg_t        addr_cfg_i,
  input  wire logic [TSEL_W-1:0]     tx_timer_sel_i,
  input  wire logic [TSEL_W-1:0]     rx_timer_sel_i,
  input  wire logic [NUM_TIMERS-1:0] timer_ovf_i,
  // CPU data access
  input  wire logic                  buf_wr_i,
  input  wire logic [DATA_W-1:0]     buf_wdata_i,
  input  wire logic                  buf_rd_i,
  input  wire logic                  clr_tx_complete_i,
  input  wire logic                  clr_rx_complete_i,
  input  wire logic                  clr_errors_i,
  // Serial line
  input  wire logic                  rx_i,
  output logic                       tx_o,
  // CPU visible state
  output logic [DATA_W-1:0]          serial_data_buffer_o,
  output unbm_status_t               status_o,
  output logic                       tx_busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic async_nine;
  logic tx_tick;
  logic tx_bit;
  logic rx_tick;
  logic tx_start;

  assign async_nine = {mode_select_high_i, mode_select_low_i} == MODE_NINE_VAR;

  unbm_baud_sel u_tx_baud (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .timer_ovf_i (timer_ovf_i),
    .timer_sel_i (tx_timer_sel_i),
    .restart_i   (tx_start),
    .tick_o      (),
    .bit_o       (tx_bit)
  );

  unbm_baud_sel u_rx_baud (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .timer_ovf_i (timer_ovf_i),
    .timer_sel_i (rx_timer_sel_i),
    .restart_i   (1'b0),
    .tick_o      (rx_tick),
    .bit_o       ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  logic [10:0] tx_shift_ff;
  logic [3:0]  tx_cnt_ff;
  logic        tx_busy_ff;
  logic        tx_ff;
  logic        tx_done_ff;
  logic        txcol_ff;

  assign tx_start = buf_wr_i && !tx_busy_ff && async_nine;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_shift_ff <= '1;
      tx_cnt_ff   <= '0;
      tx_busy_ff  <= 1'b0;
      tx_ff       <= 1'b1;
    end else if (tx_start) begin
      tx_shift_ff <= {1'b1, tx_ninth_bit_i, buf_wdata_i, 1'b0};
      tx_cnt_ff   <= '0;
      tx_busy_ff  <= 1'b1;
      tx_ff       <= 1'b0;
    end else if (tx_busy_ff && tx_bit) begin
      if (tx_cnt_ff == STOP_IDX) begin
        tx_busy_ff <= 1'b0;
        tx_ff      <= 1'b1;
      end else begin
        tx_cnt_ff   <= tx_cnt_ff + 4'h1;
        tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
        tx_ff       <= tx_shift_ff[1];
      end
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_done_ff <= 1'b0;
    end else if (tx_busy_ff && tx_bit && tx_cnt_ff == NINTH_IDX) begin
      tx_done_ff <= 1'b1;
    end else if (clr_tx_complete_i) begin
      tx_done_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      txcol_ff <= 1'b0;
    end else if (buf_wr_i && tx_busy_ff) begin
      txcol_ff <= 1'b1;
    end else if (clr_errors_i) begin
      txcol_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: samples on overflow ticks, mid-bit after start detection
  unbm_rx_state_t rx_state_ff;
  logic [3:0]  rx_tcnt_ff;
  logic [3:0]  rx_bcnt_ff;
  logic [8:0]  rx_sh_ff;
  logic        rx_done_ff;
  logic        rx_stop_ff;
  logic [DATA_W-1:0] rbuf_ff;
  logic        rb8_ff;
  logic        ri_ff;
  logic        ov_ff;
  logic        fe_ff;
  logic        unread_ff;
  logic        accept;

  function automatic logic addr_match(input logic [DATA_W-1:0] a, input unbm_addr_cfg_t c);
    logic masked;
    logic bcast;
    logic [DATA_W-1:0] bc;
    masked = ((a ^ c.own_slave_address) & c.address_mask) == '0;
    bc     = c.own_slave_address | c.address_mask;
    bcast  = (a & bc) == bc;
    return masked || bcast;
  endfunction

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_state_ff <= UNBM_IDLE;
      rx_tcnt_ff  <= '0;
      rx_bcnt_ff  <= '0;
      rx_sh_ff    <= '0;
      rx_done_ff  <= 1'b0;
      rx_stop_ff  <= 1'b0;
    end else begin
      rx_done_ff <= 1'b0;
      case (rx_state_ff)
        UNBM_IDLE: begin
          if (rx_enable_i && async_nine && !rx_i) begin
            rx_state_ff <= UNBM_START;
            rx_tcnt_ff  <= '0;
          end
        end
        UNBM_START: begin
          if (rx_tick) begin
            rx_tcnt_ff <= rx_tcnt_ff + 4'h1;
            if (rx_tcnt_ff == 4'(HALF_BIT - 1)) begin
              rx_tcnt_ff <= '0;
              rx_bcnt_ff <= '0;
              rx_state_ff <= rx_i ? UNBM_IDLE : UNBM_DATA;
            end
          end
        end
        UNBM_DATA: begin
          if (rx_tick) begin
            rx_tcnt_ff <= rx_tcnt_ff + 4'h1;
            if (rx_tcnt_ff == 4'(TICKS_PER_BIT - 1)) begin
              rx_bcnt_ff <= rx_bcnt_ff + 4'h1;
              if (rx_bcnt_ff == NINTH_IDX) begin
                rx_stop_ff  <= rx_i;
                rx_done_ff  <= 1'b1;
                rx_state_ff <= UNBM_IDLE;
              end else begin
                rx_sh_ff <= {rx_i, rx_sh_ff[8:1]};
              end
            end
          end
        end
        default: rx_state_ff <= UNBM_IDLE;
      endcase
    end
  end

  assign accept = rx_done_ff && !ri_ff &&
                  (!multiproc_enable_i || (rx_sh_ff[8] && addr_match(rx_sh_ff[7:0], addr_cfg_i)));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rbuf_ff <= RST_BYTE;
      rb8_ff  <= 1'b0;
    end else if (accept) begin
      rbuf_ff <= rx_sh_ff[7:0];
      rb8_ff  <= rx_sh_ff[8];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ri_ff <= 1'b0;
    end else if (accept) begin
      ri_ff <= 1'b1;
    end else if (clr_rx_complete_i) begin
      ri_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      unread_ff <= 1'b0;
    end else if (accept) begin
      unread_ff <= 1'b1;
    end else if (buf_rd_i) begin
      unread_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ov_ff <= 1'b0;
      fe_ff <= 1'b0;
    end else begin
      if (accept && unread_ff && !buf_rd_i) begin
        ov_ff <= 1'b1;
      end else if (clr_errors_i) begin
        ov_ff <= 1'b0;
      end
      if (rx_done_ff && !rx_stop_ff) begin
        fe_ff <= 1'b1;
      end else if (clr_errors_i) begin
        fe_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign tx_o                 = tx_ff;
  assign serial_data_buffer_o = rbuf_ff;
  assign tx_busy_o            = tx_busy_ff;
  assign status_o             = '{tx_collision_flag: txcol_ff, rx_overrun_flag: ov_ff,
                                  frame_error_flag: fe_ff, rx_complete_flag: ri_ff,
                                  tx_complete_flag: tx_done_ff, rx_ninth_bit: rb8_ff};

  ////////////////////////////////////////////////////////////////////////////
  frame_start_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tx_start |=> !tx_o && tx_busy_o) else $error("start bit not driven");
  ninth_bit_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tx_start |=> tx_shift_ff[9] == $past(tx_ninth_bit_i)) else $error("ninth bit not loaded");
  tx_done_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (tx_busy_ff && tx_bit && tx_cnt_ff == NINTH_IDX) |=> status_o.tx_complete_flag)
    else $error("transmit complete missing");
  collision_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (buf_wr_i && tx_busy_o) |=> status_o.tx_collision_flag) else $error("collision not flagged");
  reject_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rx_done_ff && multiproc_enable_i && !rx_sh_ff[8]) |=> $stable(serial_data_buffer_o))
    else $error("rejected frame altered buffer");
  accept_load_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    accept |=> status_o.rx_complete_flag && serial_data_buffer_o == $past(rx_sh_ff[7:0]))
    else $error("accepted byte not stored");
  frame_err_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rx_done_ff && !rx_stop_ff) |=> status_o.frame_error_flag) else $error("frame error missed");
  overrun_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (accept && unread_ff && !buf_rd_i) |=> status_o.rx_overrun_flag) else $error("overrun missed");
  bcast_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (rx_done_ff && !ri_ff && multiproc_enable_i && rx_sh_ff == 9'h1ff) |-> accept)
    else $error("broadcast all ones refused");

  // Slowest timer: ten bit times of sixteen ticks, four cycles per tick, plus pipeline
  tx_frame_c: cover property (@(posedge clk_i) disable iff (!rstn_i) tx_start ##[1:800] status_o.tx_complete_flag);
  rx_accept_c: cover property (@(posedge clk_i) disable iff (!rstn_i) accept && multiproc_enable_i);
  rx_reject_c: cover property (@(posedge clk_i) disable iff (!rstn_i) rx_done_ff && !accept);
  overrun_c: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(status_o.rx_overrun_flag));

endmodule

// [unbm_peer_model.sv]
// Far-end processor UART model: drives the device receive line and decodes its transmit line
`timescale 1ns/1ns
module unbm_peer_model (
  // Clock and bit ticks
  input  wire logic clk_i,
  input  wire logic tick_rx_i,
  input  wire logic tick_tx_i,
  // Serial lines
  input  wire logic tx_i,
  output logic      line_o
);
  // Line idles high between frames
  initial line_o = 1'b1;

  // Ends at the falling edge after the last tick so the line changes off the sampling edge
  task automatic wait_ticks(input logic use_tx, input int n);
    repeat (n) begin
      do @(posedge clk_i); while (!(use_tx ? tick_tx_i : tick_rx_i));
    end
    @(negedge clk_i);
  endtask

  // Caller picks the ninth bit: 1 for address frames, 0 for data frames
  task automatic send(input logic [8:0] bits, input logic stop);
    logic [10:0] f;
    f = {stop, bits, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_o = f[i];
      wait_ticks(1'b0, 16);
    end
    line_o = 1'b1;
  endtask

  // Samples mid-bit; returns stop, ninth, data
  task automatic recv(output logic [9:0] got);
    @(negedge tx_i);
    wait_ticks(1'b1, 8);
    for (int i = 0; i < 10; i++) begin
      wait_ticks(1'b1, 16);
      got[i] = tx_i;
    end
  endtask
endmodule

// [unbm_uart_tb_top.sv]
// Self-checking testbench for the nine-bit multiprocessor UART
`timescale 1ns/1ns
module unbm_uart_tb_top;
  import unbm_pkg::*;
  logic clk_i = 1'b0, rstn_i = 1'b0, msh = 1'b1, msl = 1'b1, mp = 1'b0, txn = 1'b0;
  logic wr = 1'b0, rd = 1'b0, ctc = 1'b0, crc = 1'b0, cer = 1'b0;
  logic [1:0] tsel = 2'h0, rsel = 2'h0;
  logic [7:0] wdata = 8'h00, sbuf, exp_buf;
  logic [3:0] ovf;
  logic [9:0] got;
  logic [9:0] exp_q [$];
  logic tx, busy, rxl, exp_n, exp_ov, exp_fe, unread;
  unbm_addr_cfg_t cfg = 16'h0000;
  unbm_status_t st;
  int tcnt = 0, error_cnt = 0, tests_run = 0;

  always #50 clk_i = ~clk_i;
  // Timer k overflows every k+1 cycles, so each selection gives its own bit rate
  always @(negedge clk_i) tcnt <= tcnt + 1;
  assign ovf = {tcnt % 4 == 0, tcnt % 3 == 0, tcnt % 2 == 0, 1'b1};

  unbm_uart u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .mode_select_high_i(msh), .mode_select_low_i(msl),
    .multiproc_enable_i(mp), .rx_enable_i(1'b1), .tx_ninth_bit_i(txn), .addr_cfg_i(cfg),
    .tx_timer_sel_i(tsel), .rx_timer_sel_i(rsel), .timer_ovf_i(ovf), .buf_wr_i(wr), .buf_wdata_i(wdata),
    .buf_rd_i(rd), .clr_tx_complete_i(ctc), .clr_rx_complete_i(crc), .clr_errors_i(cer), .rx_i(rxl),
    .tx_o(tx), .serial_data_buffer_o(sbuf), .status_o(st), .tx_busy_o(busy));
  unbm_peer_model u_peer (.clk_i(clk_i), .tick_rx_i(ovf[rsel]), .tick_tx_i(ovf[tsel]), .tx_i(tx),
    .line_o(rxl));

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Receive one frame; rdb=0 leaves the byte unread so the next accept overruns
  task automatic rx_case(input logic [7:0] a, m, d, input logic n, p, s, rdb);
    logic acc;
    acc = !p || (n && ((((a ^ d) & m) == 8'h00) || (((a | m) & ~d) == 8'h00)));
    cfg = {a, m};
    mp = p;
    u_peer.send({n, d}, s);
    repeat (4) @(negedge clk_i);
    if (acc) begin
      exp_ov = exp_ov | unread;
      exp_buf = d;
      exp_n = n;
      unread = 1'b1;
    end
    exp_fe = exp_fe | !s;
    chk(st.rx_complete_flag, acc);
    chk(sbuf, exp_buf);
    chk(st.rx_ninth_bit, exp_n);
    chk(st.frame_error_flag, exp_fe);
    chk(st.rx_overrun_flag, exp_ov);
    crc = 1'b1;
    rd = rdb;
    cer = rdb;
    @(negedge clk_i);
    {crc, rd, cer} = 3'h0;
    if (rdb) {unread, exp_ov, exp_fe} = 3'h0;
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    give_verdict();
  end

  initial begin
    logic [7:0] masks [3];
    logic [7:0] data [4];
    masks = '{8'h0f, 8'hf3, 8'hc0};
    void'($urandom(94015));
    {exp_buf, exp_n, exp_ov, exp_fe, unread} = 12'h000;
    repeat (3) @(negedge clk_i);
    chk({tx, busy, sbuf}, 10'h200);
    chk(st, 6'h00);
    rstn_i = 1'b1;
    // Masked, broadcast, all-ones and random addresses against the three mask examples
    for (int i = 0; i < 12; i++) begin
      data = '{8'hf5, 8'hff, 8'h35, 8'($urandom)};
      rsel = 2'(i);
      rx_case(8'h35, masks[i % 3], data[i % 4], 1'($urandom), 1'b1, 1'b1, 1'b1);
    end
    // Slave takes a broadcast address, drops address mode for the data, then rearms it
    rx_case(8'h35, 8'h0f, 8'hff, 1'b1, 1'b1, 1'b1, 1'b1);
    rx_case(8'h35, 8'h0f, 8'($urandom), 1'b0, 1'b0, 1'b1, 1'b1);
    rx_case(8'h35, 8'h0f, 8'hf5, 1'b0, 1'b1, 1'b1, 1'b1);
    rx_case(8'h12, 8'hff, 8'($urandom), 1'b0, 1'b0, 1'b1, 1'b0);
    rx_case(8'h12, 8'hff, 8'($urandom), 1'b1, 1'b0, 1'b1, 1'b1);
    rx_case(8'h35, 8'hff, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      tsel = 2'(3 - i);
      rsel = 2'(i);
      txn = 1'($urandom);
      wdata = 8'($urandom);
      // Expected frame as the far end sees it: stop, ninth, data
      exp_q.push_back({1'b1, txn, wdata});
      fork
        u_peer.recv(got);
        begin
          wr = 1'b1;
          @(negedge clk_i);
          wr = 1'b0;
        end
      join
      chk(got, exp_q.pop_front());
      chk(st.tx_complete_flag, 1'b1);
      chk(st.tx_collision_flag, 1'b0);
      wr = 1'b1;
      @(negedge clk_i);
      wr = 1'b0;
      chk(st.tx_collision_flag, 1'b1);
      for (int k = 0; k < 400 && busy !== 1'b0; k++) @(negedge clk_i);
      repeat (3) @(negedge clk_i);
      chk({busy, tx}, 2'h1);
      {ctc, cer} = 2'h3;
      @(negedge clk_i);
      {ctc, cer} = 2'h0;
      chk({st.tx_complete_flag, st.tx_collision_flag}, 2'h0);
    end
    // Writes outside the nine-bit variable-rate mode start nothing
    msh = 1'b0;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
    repeat (3) @(negedge clk_i);
    chk({busy, tx}, 2'h1);
    give_verdict();
  end
endmodule
